// >>> rtl/tlia_arbiter.sv
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Two-level interrupt arbiter with Avalon-MM register access
module tlia_arbiter
  import tlia_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [NUM_SRC-1:0]  src_set,
  input  wire logic                insn_done,
  input  wire logic                reti_done,
  output logic                     call_req,
  output logic [15:0]              call_vector,
  output logic                     isr_entry,
  output logic [NUM_SRC-1:0]       pending_flags,
  output logic                     level_high,
  output logic                     level_low
);
  logic [7:0]         basic_en_q;
  logic [7:0]         basic_pri_q;
  logic [7:0]         ext_en_a_q;
  logic [7:0]         ext_en_b_q;
  logic [7:0]         ext_pri_a_q;
  logic [7:0]         ext_pri_b_q;
  logic               wait_q;
  logic [31:0]        rdata_q;
  tlia_state_t        st_q;
  tlia_state_t        st_d;
  logic [2:0]         cnt_q;
  logic               act_hi_q;
  logic               act_lo_q;
  logic               samp_valid_q;
  logic               samp_high_q;
  logic [ORD_W-1:0]   samp_ord_q;
  logic [ORD_W-1:0]   call_ord_q;
  logic               call_req_q;
  logic [15:0]        call_vec_q;
  logic               entry_q;

  // Bus decode
  wire                req_any   = avs_read | avs_write;
  wire                wr_fire   = avs_write & ~wait_q & avs_byteenable[0];
  wire [7:0]          wbyte     = avs_writedata[7:0];
  wire                we_ben    = wr_fire && avs_address == ADDR_BASIC_EN;
  wire                we_bpri   = wr_fire && avs_address == ADDR_BASIC_PRI;
  wire                we_ena    = wr_fire && avs_address == ADDR_EXT_EN_A;
  wire                we_enb    = wr_fire && avs_address == ADDR_EXT_EN_B;
  wire                we_pria   = wr_fire && avs_address == ADDR_EXT_PRI_A;
  wire                we_prib   = wr_fire && avs_address == ADDR_EXT_PRI_B;
  wire                we_pend   = avs_write && !wait_q && avs_address == ADDR_PENDING;

  // Per-source enable and priority, same bit positions in both register sets
  wire [NUM_SRC-1:0]  en_all    = {ext_en_b_q[EXT_B_SRCS-1:0], ext_en_a_q, basic_en_q[BASIC_SRCS-1:0]};
  wire [NUM_SRC-1:0]  pri_all   = {ext_pri_b_q[EXT_B_SRCS-1:0], ext_pri_a_q, basic_pri_q[BASIC_SRCS-1:0]};
  wire                global_en = basic_en_q[GLOBAL_EN_BIT];
  wire [NUM_SRC-1:0]  pend;
  wire [NUM_SRC-1:0]  eligible  = pend & en_all & {NUM_SRC{global_en}};
  wire [NUM_SRC-1:0]  hi_req    = eligible & pri_all;
  wire [NUM_SRC-1:0]  lo_req    = eligible & ~pri_all;
  wire                hi_valid;
  wire                lo_valid;
  wire [ORD_W-1:0]    hi_idx;
  wire [ORD_W-1:0]    lo_idx;

  // Service admission: high preempts low only, nothing preempts high
  wire                allowed   = samp_high_q ? !act_hi_q : (!act_hi_q && !act_lo_q);
  wire                start     = st_q == ST_RUN && insn_done && samp_valid_q && allowed;
  wire [15:0]         vec_calc  = VEC_BASE + {8'h00, samp_ord_q, 3'b000};
  wire [NUM_SRC-1:0]  hw_clr;
  wire [NUM_SRC-1:0]  pend_wval = avs_writedata[NUM_SRC-1:0];
  wire [31:0]         status_w  = {22'h000000, st_q, act_hi_q, act_lo_q, 1'b0, call_ord_q};

  // Read mux, unmapped addresses read as zero
  wire [31:0]         rd_mux    =
    avs_address == ADDR_BASIC_EN  ? {24'h000000, basic_en_q} :
    avs_address == ADDR_BASIC_PRI ? {24'h000000, basic_pri_q} :
    avs_address == ADDR_EXT_EN_A  ? {24'h000000, ext_en_a_q} :
    avs_address == ADDR_EXT_EN_B  ? {24'h000000, ext_en_b_q} :
    avs_address == ADDR_EXT_PRI_A ? {24'h000000, ext_pri_a_q} :
    avs_address == ADDR_EXT_PRI_B ? {24'h000000, ext_pri_b_q} :
    avs_address == ADDR_PENDING   ? {10'h000, pend} :
    avs_address == ADDR_STATUS    ? status_w : 32'h00000000;

  tlia_prio_enc #(.W(NUM_SRC)) u_enc_hi (
    .req   (hi_req),
    .valid (hi_valid),
    .idx   (hi_idx)
  );

  tlia_prio_enc #(.W(NUM_SRC)) u_enc_lo (
    .req   (lo_req),
    .valid (lo_valid),
    .idx   (lo_idx)
  );

  // Pending flags; only the first four clear on vectoring, read-only ones ignore writes
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_flag
    assign hw_clr[g] = start && samp_ord_q == ORD_W'(g);
    tlia_flag #(.HW_CLR(HW_CLR_MASK[g]), .SW_WR(!RO_MASK[g])) u_flag (
      .clk    (clk),
      .rst_n  (rst_n),
      .set_ev (src_set[g]),
      .sw_we  (we_pend && avs_byteenable[g/8]),
      .sw_val (pend_wval[g]),
      .hw_clr (hw_clr[g]),
      .flag_q (pend[g])
    );
  end

  // One wait state on every access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= ~(req_any & wait_q);
      rdata_q <= rd_mux;
    end
  end

  // Enable and priority registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      basic_en_q  <= EN_RST;
      ext_en_a_q  <= EN_RST;
      ext_en_b_q  <= EN_RST;
      basic_pri_q <= PRI_RST;
      ext_pri_a_q <= PRI_RST;
      ext_pri_b_q <= PRI_RST;
    end else begin
      if (we_ben)  basic_en_q  <= wbyte;
      if (we_bpri) basic_pri_q <= wbyte;
      if (we_ena)  ext_en_a_q  <= wbyte;
      if (we_enb)  ext_en_b_q  <= wbyte;
      if (we_pria) ext_pri_a_q <= wbyte;
      if (we_prib) ext_pri_b_q <= wbyte;
    end
  end

  // Detection stage: sample and decode every clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_valid_q <= 1'b0;
      samp_high_q  <= 1'b0;
      samp_ord_q   <= '0;
    end else begin
      samp_valid_q <= hi_valid | lo_valid;
      samp_high_q  <= hi_valid;
      samp_ord_q   <= hi_valid ? hi_idx : lo_idx;
    end
  end

  // Sequencer: long call, and one instruction of grace after a return
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (start) begin
          st_d = ST_CALL;
        end else if (reti_done) begin
          st_d = ST_AFTER_RETI;
        end
      end
      ST_CALL: begin
        if (cnt_q == 3'h0) begin
          st_d = ST_RUN;
        end
      end
      ST_AFTER_RETI: begin
        if (insn_done) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ST_RUN;
      cnt_q      <= 3'h0;
      call_req_q <= 1'b0;
      entry_q    <= 1'b0;
      call_vec_q <= VEC_RESET;
      call_ord_q <= '0;
    end else begin
      st_q       <= st_d;
      call_req_q <= st_d == ST_CALL;
      entry_q    <= st_q == ST_CALL && st_d == ST_RUN;
      cnt_q      <= start ? LCALL_LAST : (cnt_q != 3'h0 ? cnt_q - 3'h1 : 3'h0);
      if (start) begin
        call_vec_q <= vec_calc;
        call_ord_q <= samp_ord_q;
      end
    end
  end

  // Active levels; a return ends the high routine first so a low one resumes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_hi_q <= 1'b0;
      act_lo_q <= 1'b0;
    end else if (start) begin
      act_hi_q <= act_hi_q | samp_high_q;
      act_lo_q <= act_lo_q | !samp_high_q;
    end else if (reti_done) begin
      if (act_hi_q) begin
        act_hi_q <= 1'b0;
      end else begin
        act_lo_q <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops
  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign call_req        = call_req_q;
  assign call_vector     = call_vec_q;
  assign isr_entry       = entry_q;
  assign pending_flags   = pend;
  assign level_high      = act_hi_q;
  assign level_low       = act_lo_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_call_run;
    call_req_q [*5];
  endsequence

  sequence s_entry;
    !call_req_q && entry_q;
  endsequence

  AST_CALL_FIVE: assert property (
    start |=> s_call_run ##1 s_entry) else $error("long call not five clocks");
  AST_NO_PREEMPT_HIGH: assert property (
    start |-> !act_hi_q) else $error("high routine preempted");
  AST_HIGH_FIRST: assert property (
    (hi_valid |=> samp_high_q && samp_valid_q)) else $error("low request beat high");
  AST_VECTOR: assert property (
    start |=> call_vector == VEC_BASE + {8'h00, $past(samp_ord_q), 3'b000}) else $error("bad vector");
  AST_HW_CLEAR: assert property (
    start && samp_ord_q < 5'd4 && !src_set[samp_ord_q] |=> !pend[$past(samp_ord_q)])
    else $error("flag not cleared on vectoring");
  AST_KEEP_FLAG: assert property (
    start && samp_ord_q == 5'd10 && !we_pend && !$past(we_pend) |=> pend[ORD_CONV_DONE])
    else $error("conversion flag cleared");
  AST_GRACE: assert property (
    reti_done && st_q == ST_RUN && !start |=> !start) else $error("call right after return");
  AST_GLOBAL: assert property (
    $rose(samp_valid_q) |-> $past(global_en)) else $error("request with global enable off");
  AST_RESUME: assert property (
    reti_done && !start && act_hi_q && act_lo_q |=> act_lo_q && !act_hi_q) else $error("low routine lost");
  AST_LOW_DEFAULT: assert property (
    $rose(rst_n) |-> pri_all == '0) else $error("priority not low after reset");
  AST_WAIT_ONE: assert property (
    req_any && wait_q |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing");

  // Fixed order inside each level: the granted index is set and nothing below it is
  AST_LOWEST_HI: assert property (
    hi_valid |-> hi_req[hi_idx] && (hi_req & ((NUM_SRC'(1) << hi_idx) - NUM_SRC'(1))) == '0)
    else $error("high grant not lowest order");
  AST_LOWEST_LO: assert property (
    lo_valid |-> lo_req[lo_idx] && (lo_req & ((NUM_SRC'(1) << lo_idx) - NUM_SRC'(1))) == '0)
    else $error("low grant not lowest order");

  // Sample stage follows the eligible set one clock later, gated by global enable
  AST_SAMPLE_EVERY: assert property (
    samp_valid_q == ($past(eligible) != '0)) else $error("request not sampled");
  AST_GLOBAL_OFF: assert property (
    !$past(global_en) |-> !samp_valid_q && !start) else $error("call with global enable off");

  // Admission by level: equal or higher waits, high over low goes at the boundary
  AST_WAIT_LEVEL: assert property (
    samp_valid_q && (act_hi_q || (act_lo_q && !samp_high_q)) |-> !start)
    else $error("equal level not held off");
  AST_HIGH_PREEMPTS: assert property (
    st_q == ST_RUN && insn_done && samp_valid_q && samp_high_q && !act_hi_q |-> start)
    else $error("high request did not preempt");

  sequence s_reti_in_run;
    reti_done && st_q == ST_RUN && !start;
  endsequence

  // Grace instruction after a return, then the sequencer is free again
  AST_GRACE_HOLD: assert property (
    s_reti_in_run ##1 !insn_done |=> !start) else $error("call inside grace");
  AST_GRACE_END: assert property (
    st_q == ST_AFTER_RETI && insn_done |=> st_q == ST_RUN) else $error("grace never ends");

  // Vector, entry pulse and flags that must survive vectoring or software writes
  AST_CONV_VECTOR: assert property (
    start && samp_ord_q == ORD_W'(ORD_CONV_DONE) |=> call_vector == VEC_BASE + 16'(8 * ORD_CONV_DONE))
    else $error("conversion vector wrong");
  AST_ENTRY_ONE: assert property (
    isr_entry |=> !isr_entry) else $error("entry pulse too long");
  AST_RO_KEEP: assert property (
    we_pend && (pend & RO_MASK) == RO_MASK |=> (pend & RO_MASK) == RO_MASK)
    else $error("read-only flag cleared");
  AST_KEEP_OTHERS: assert property (
    start && samp_ord_q >= 5'd4 && !we_pend && !$past(we_pend) |=> pend[$past(samp_ord_q)])
    else $error("software-cleared flag lost on vectoring");
endmodule

// >>> shared/tlia_pkg.sv
// Functional notes
// - Every source has one priority bit choosing the low or high level.
// - High level preempts a running low routine; nothing preempts a high routine.
// - A preempted low routine resumes after the high routine returns.
// - All priority bits clear to the low level at reset.
// - Among simultaneous requests, a high-level request wins over low-level ones.
// - Within one level the smallest order number wins; orders run 0 to 21.
// - Pending requests are sampled and priority decoded on every clock.
// - Fastest entry is 7 clocks, of which the long call takes 5.
// - After a return, exactly one more instruction runs before the next call; the code lets two instructions end before the call.
// - Worst case with no competing routine is 19 clocks, 1+5+8+5.
// - A request at equal or lower level waits for return plus one instruction.
// - Reset vector is 0x0000; source vector is 0x0003 plus eight times order.
// - Only external 0/1 and timer 0/1 flags clear by hardware on vectoring.
// - Conversion-done uses order 10, vector 0x0053, own enable and priority bits.
// - A read-only flag cannot be cleared by software; only its enable stops it.
// - Priority bits sit at the same positions as the matching enable bits.
// - A flag sets on its event whatever its enable state.
// - Individual enables count only while global enable bit 7 is set.
// - A flag still set after a return raises a new request after one instruction.
package tlia_pkg;
  localparam int          NUM_SRC        = 22;
  localparam int          ORD_W          = 5;
  localparam int          CLK_PERIOD_NS  = 50;
  // Register byte addresses
  localparam logic [4:0]  ADDR_BASIC_EN  = 5'h00;
  localparam logic [4:0]  ADDR_BASIC_PRI = 5'h04;
  localparam logic [4:0]  ADDR_EXT_EN_A  = 5'h08;
  localparam logic [4:0]  ADDR_EXT_EN_B  = 5'h0c;
  localparam logic [4:0]  ADDR_EXT_PRI_A = 5'h10;
  localparam logic [4:0]  ADDR_EXT_PRI_B = 5'h14;
  localparam logic [4:0]  ADDR_PENDING   = 5'h18;
  localparam logic [4:0]  ADDR_STATUS    = 5'h1c;
  // Reset values and field positions
  localparam logic [7:0]  EN_RST         = 8'h00;
  localparam logic [7:0]  PRI_RST        = 8'h00;
  localparam int          GLOBAL_EN_BIT  = 7;
  localparam int          BASIC_SRCS     = 7;
  localparam int          EXT_A_SRCS     = 8;
  localparam int          EXT_B_SRCS     = 7;
  localparam logic [21:0] HW_CLR_MASK    = 22'h00000f;
  localparam logic [21:0] RO_MASK        = 22'h008000;
  localparam int          ORD_CONV_DONE  = 10;
  // Vectors
  localparam logic [15:0] VEC_RESET      = 16'h0000;
  localparam logic [15:0] VEC_BASE       = 16'h0003;
  // Timing in system clocks
  localparam int          DETECT_CLKS    = 1;
  localparam int          LCALL_CLKS     = 5;
  localparam int          MIN_LAT_CLKS   = 7;
  localparam int          MAX_LAT_CLKS   = 19;
  localparam logic [2:0]  LCALL_LAST     = 3'(LCALL_CLKS - 1);

  typedef enum logic [1:0] {
    ST_RUN        = 2'b00,
    ST_CALL       = 2'b01,
    ST_AFTER_RETI = 2'b10
  } tlia_state_t;
endpackage

// >>> rtl/tlia_flag.sv
`timescale 1ns/1ps
// One interrupt pending flag; an event wins over any clear in the same cycle
module tlia_flag
  import tlia_pkg::*;
#(
  parameter bit HW_CLR = 1'b0,
  parameter bit SW_WR  = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_ev,
  input  wire logic sw_we,
  input  wire logic sw_val,
  input  wire logic hw_clr,
  output logic      flag_q
);
  logic flag_d;

  // Event first, then vectoring clear, then software write
  always_comb begin
    flag_d = flag_q;
    if (set_ev) begin
      flag_d = 1'b1;
    end else if (hw_clr && HW_CLR) begin
      flag_d = 1'b0;
    end else if (sw_we && SW_WR) begin
      flag_d = sw_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  AST_FLAG_SETS: assert property (@(posedge clk) disable iff (!rst_n)
    set_ev |=> flag_q) else $error("pending flag lost its event");
endmodule

// >>> rtl/tlia_prio_enc.sv
`timescale 1ns/1ps
// Fixed-order encoder: the lowest set index wins
module tlia_prio_enc
  import tlia_pkg::*;
#(
  parameter int W = NUM_SRC
) (
  input  wire logic [W-1:0]     req,
  output logic                  valid,
  output logic [ORD_W-1:0]      idx
);
  // Scan from the top so the smallest index is written last
  always_comb begin
    valid = 1'b0;
    idx   = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx   = ORD_W'(i);
      end
    end
  end
endmodule

// >>> sim/tlia_cpu_model.sv
`timescale 1ns/1ps
// Instruction pipeline stand-in: one boundary per gap+1 cycles, stalled during a long call
module tlia_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       call_req,
  input  wire logic       ret_go,
  input  wire logic [3:0] gap,
  output logic            insn_done,
  output logic            reti_done
);
  logic [3:0] cnt_q;
  logic       ret_q;

  // A pending return takes the next instruction slot, never one inside a call
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= '0;
      ret_q     <= 1'b0;
      insn_done <= 1'b0;
      reti_done <= 1'b0;
    end else begin
      insn_done <= 1'b0;
      reti_done <= 1'b0;
      if (ret_go) begin
        ret_q <= 1'b1;
      end
      if (call_req) begin
        cnt_q <= '0;
      end else if (cnt_q >= gap) begin
        cnt_q <= '0;
        if (ret_q || ret_go) begin
          reti_done <= 1'b1;
          ret_q     <= 1'b0;
        end else begin
          insn_done <= 1'b1;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb
  import tlia_pkg::*;
;
  logic                clk;
  logic                rst_n;
  logic [4:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic [NUM_SRC-1:0]  src_set;
  logic [NUM_SRC-1:0]  pending_flags;
  logic [NUM_SRC-1:0]  m;
  logic                insn_done;
  logic                reti_done;
  logic                call_req;
  logic [15:0]         call_vector;
  logic                isr_entry;
  logic                level_high;
  logic                level_low;
  logic                ret_go;
  logic                garm;
  logic [3:0]          gap;
  logic [17:0]         exp_q[$];
  logic [17:0]         e;
  logic [31:0]         rd;
  int                  num_errors, cmp_count, ccnt, gcnt, cyc, n, k;
  int                  ords[8] = '{0, 1, 2, 3, 10, 14, 20, 21};

  tlia_arbiter i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_set(src_set),
    .insn_done(insn_done), .reti_done(reti_done), .call_req(call_req), .call_vector(call_vector),
    .isr_entry(isr_entry), .pending_flags(pending_flags), .level_high(level_high), .level_low(level_low));
  tlia_cpu_model i_cpu (.clk(clk), .rst_n(rst_n), .call_req(call_req), .ret_go(ret_go), .gap(gap),
    .insn_done(insn_done), .reti_done(reti_done));

  // Clock
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Bus cycles hold the request until waitrequest is sampled low
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic pulse(input logic [NUM_SRC-1:0] mask);
    @(posedge clk);
    src_set <= mask;
    @(posedge clk);
    src_set <= '0;
  endtask

  task automatic wait_entry();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (isr_entry !== 1'b1 && n < 100);
    if (isr_entry !== 1'b1) check("entry_wait", 0, 1);
  endtask

  task automatic ret();
    @(posedge clk);
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    repeat (12) @(negedge clk);
  endtask

  // Monitor: call length, grace count, vector and level against the oldest note
  always @(negedge clk) begin
    if (reti_done === 1'b1) gcnt = 0;
    if (garm && call_req === 1'b1 && ccnt == 0) begin
      check("grace", gcnt, 2);
      garm = 1'b0;
    end
    if (garm && insn_done === 1'b1) gcnt++;
    if (call_req === 1'b1) ccnt++;
    else if (ccnt != 0) begin
      check("call_len", ccnt, LCALL_CLKS);
      ccnt = 0;
    end
    if (isr_entry === 1'b1) begin
      if (exp_q.size() == 0) check("stray_entry", 1, 0);
      else begin
        e = exp_q.pop_front();
        check("vector", call_vector, e[17:2]);
        check("level", {level_high, level_low}, e[1:0]);
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    rst_n = 1'b0; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = '0;
    avs_byteenable = 4'hf; src_set = '0; ret_go = 1'b0; gap = 4'h0; garm = 1'b0;
    num_errors = 0; cmp_count = 0; ccnt = 0; gcnt = 0; cyc = 0;
    void'($urandom(30));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      bus_rd(5'(a * 4), rd);
      check("reg_rst", rd, 0);
    end
    bus_rd(5'h02, rd);
    check("unmapped", rd, 0);
    bus_wr(ADDR_BASIC_EN, 32'h81, 4'he);
    bus_rd(ADDR_BASIC_EN, rd);
    check("lane_off", rd, 0);
    check("vec_rst", call_vector, VEC_RESET);
    // Fastest entry with a boundary every cycle
    bus_wr(ADDR_BASIC_EN, 32'h81);
    exp_q.push_back({VEC_BASE, 2'b01});
    pulse(22'h1);
    wait_entry();
    check("latency", n, MIN_LAT_CLKS + 1);
    ret();
    // Fixed order among random competitors of the same level
    bus_wr(ADDR_BASIC_EN, 32'hff);
    bus_wr(ADDR_EXT_EN_A, 32'hff);
    bus_wr(ADDR_EXT_EN_B, 32'h7e);
    foreach (ords[i]) begin
      k = ords[i];
      gap = 4'($urandom_range(0, 3));
      m = (NUM_SRC'($urandom) & ~RO_MASK & ~((22'h1 << (k + 1)) - 22'h1)) | (22'h1 << k);
      exp_q.push_back({VEC_BASE + 16'(8 * k), 2'b01});
      pulse(m);
      wait_entry();
      check("hw_clr", 32'(pending_flags[k]), 32'(k >= 4));
      bus_wr(ADDR_PENDING, 0);
      ret();
    end
    // High beats low, blocks low, preempts low; low resumes
    gap = 4'h2;
    bus_wr(ADDR_BASIC_PRI, 32'h20);
    exp_q.push_back({VEC_BASE + 16'h28, 2'b10});
    pulse(22'h21);
    wait_entry();
    bus_wr(ADDR_PENDING, 32'h1);
    repeat (20) @(posedge clk);
    exp_q.push_back({VEC_BASE, 2'b01});
    garm = 1'b1;
    ret();
    if (isr_entry !== 1'b1) wait_entry();
    exp_q.push_back({VEC_BASE + 16'h28, 2'b11});
    pulse(22'h20);
    wait_entry();
    bus_wr(ADDR_PENDING, 0);
    ret();
    check("resume", {level_high, level_low}, 2'b01);
    ret();
    check("idle", {level_high, level_low}, 2'b00);
    bus_wr(ADDR_BASIC_PRI, 0);
    // Global enable holds requests; a disabled flag still sets
    bus_wr(ADDR_BASIC_EN, 32'h0f);
    pulse(22'h11);
    repeat (20) @(negedge clk);
    check("held", pending_flags[4:0], 5'h11);
    exp_q.push_back({VEC_BASE, 2'b01});
    bus_wr(ADDR_BASIC_EN, 32'h81);
    wait_entry();
    ret();
    check("masked", pending_flags[4], 1'b1);
    bus_wr(ADDR_PENDING, 0);
    // Read-only flag: re-entry while enabled, stopped only by its enable
    bus_wr(ADDR_EXT_EN_B, 32'h01);
    exp_q.push_back({VEC_BASE + 16'h78, 2'b01});
    exp_q.push_back({VEC_BASE + 16'h78, 2'b01});
    pulse(22'h8000);
    wait_entry();
    bus_wr(ADDR_PENDING, 0);
    bus_rd(ADDR_PENDING, rd);
    check("ro_flag", rd, 32'h8000);
    ret();
    if (isr_entry !== 1'b1) wait_entry();
    bus_wr(ADDR_EXT_EN_B, 0);
    ret();
    // Extended priority bit at its enable position lifts conversion-done over order 0
    bus_wr(ADDR_EXT_PRI_A, 32'h08);
    exp_q.push_back({VEC_BASE + 16'(8 * ORD_CONV_DONE), 2'b10});
    exp_q.push_back({VEC_BASE, 2'b01});
    pulse(22'h401);
    wait_entry();
    bus_wr(ADDR_PENDING, 32'h1);
    ret();
    if (isr_entry !== 1'b1) wait_entry();
    ret();
    bus_wr(ADDR_EXT_PRI_A, 0);
    repeat (20) @(negedge clk);
    check("queue", exp_q.size(), 0);
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("rst_pend", pending_flags, 0);
    check("rst_vec", call_vector, VEC_RESET);
    results();
  end
endmodule
